// ===== src/pswr_pkg.sv
// Constants, register map and state type for the power state and reset controller
package pswr_pkg;
    localparam int CLK_MHZ = 200;
    localparam int POR_DONE_US = 2326;
    localparam int POR_CYCLES = POR_DONE_US * CLK_MHZ;
    localparam int SOFT_RST_CYCLES = 16;
    localparam int NUM_PINS = 18;
    localparam int SHELF_PIN_A = 14;
    localparam int SHELF_PIN_B = 17;
    localparam int NUM_BLK = 8;
    // Wake enable / source bit positions
    localparam int WK_SLEEP_TMR = 0;
    localparam int WK_CMP_ONE = 1;
    localparam int WK_CMP_TWO = 2;
    localparam int WK_RTC = 3;
    localparam int WK_RTC_SEC = 4;
    localparam int WK_PIN0 = 5;
    localparam int WAKE_W = WK_PIN0 + NUM_PINS;
    // Register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_WAKE_EN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_CAUSE = 8'h10;
    localparam logic [7:0] REG_SOFT = 8'h14;
    localparam logic [7:0] REG_BLK = 8'h18;
    localparam logic [7:0] REG_SLEEP_TMR = 8'h1c;
    // Field positions
    localparam int CFG_XTAL_WAIT = 0;
    localparam int CFG_HCLK_RO = 1;
    localparam int SOFT_SYS = 0;
    localparam int ST_XTAL = 3;
    localparam int ST_MCUCLK = 4;
    localparam int ST_POR = 5;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_BROWN = 2;
    localparam int CAUSE_SOFT = 3;
    localparam int CAUSE_WDT = 4;
    localparam int CAUSE_W = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Gray codes along ramp -> active -> sleep -> power-down -> deep -> shelf
    typedef enum logic [2:0] {
        PS_RAMP = 3'h0,
        PS_ACTIVE = 3'h1,
        PS_SLEEP = 3'h3,
        PS_PDOWN = 3'h2,
        PS_DPDOWN = 3'h6,
        PS_SHELF = 3'h7,
        PS_RADIO = 3'h5
    } pswr_state_t;
endpackage

// ===== src/pswr_rstgen.sv
// Reset combiner: power-on hold, soft/watchdog reset stretch and cause record
`timescale 1ns/1ps
module pswr_rstgen
    import pswr_pkg::*;
#(
    parameter int POR_WAIT = POR_CYCLES
)(
    input wire logic clock,                  // 200 MHz clock
    input wire logic srst,                   // Block reset
    input wire logic glob,                   // Any global reset source
    input wire logic por_low,                // Power-on reset seen
    input wire logic pin_low,                // Reset pin seen
    input wire logic brown_high,             // Brown-out seen
    input wire logic wdt,                    // Watchdog expiry
    input wire logic sw_sys,                 // Soft reset pulse
    input wire logic clk_ready,              // Main clock ready
    input wire logic sup_ready,              // Digital supply ready
    input wire logic [CAUSE_W-1:0] cause_clr, // Write-one-to-clear
    output logic por_hold,                   // Internal power-on reset
    output logic sys_rst,                    // Reset to digital logic
    output logic [CAUSE_W-1:0] cause         // Last reset cause
);
    localparam int PW = $clog2(POR_WAIT + 1);
    localparam int SW = $clog2(SOFT_RST_CYCLES + 1);
    localparam logic [PW-1:0] POR_LAST = PW'(POR_WAIT);

    if (POR_WAIT < 1)
    begin : g_chk
        $error("POR_WAIT must be at least one cycle");
    end

    logic [PW-1:0] por_cnt;
    logic [SW-1:0] soft_cnt;
    logic por_done;
    logic soft_hit;
    logic [CAUSE_W-1:0] cause_set;

    assign por_done = (por_cnt == POR_LAST) && clk_ready && sup_ready;
    assign soft_hit = sw_sys || wdt;
    assign cause_set = {wdt, sw_sys, brown_high, pin_low, por_low};

    // Global sources clear the whole generator; only the cause survives
    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            por_cnt <= '0;
            por_hold <= 1'b1;
        end
        else
        begin
            if (por_cnt != POR_LAST)
            begin
                por_cnt <= por_cnt + PW'(1);
            end
            por_hold <= !por_done;
        end
    end

    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            soft_cnt <= '0;
            sys_rst <= 1'b1;
        end
        else
        begin
            if (soft_hit)
            begin
                soft_cnt <= SW'(SOFT_RST_CYCLES);
            end
            else if (soft_cnt != '0)
            begin
                soft_cnt <= soft_cnt - SW'(1);
            end
            sys_rst <= soft_hit || (soft_cnt > SW'(1)) || !por_done;
        end
    end

    // Set beats clear so a reset in the clearing cycle is still recorded
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cause <= '0;
        end
        else
        begin
            cause <= (cause & ~cause_clr) | cause_set;
        end
    end
endmodule

// ===== src/pswr_top.sv
// Power state controller, wakeup logic and reset control with AXI4-Lite registers
//
// Overview of operation
// - From active, software picks the next state
// - Interrupt or sleep timer wakes sleep and power-down
// - Deep power-down wake forces ramp, supplies on
// - Supply and oscillator ready enter active
// - Crystal powered during every wakeup
// - Optional hold of MCU clock for crystal
// - Sleep timer expiry raises wake event
// - Timer, comparators, pins, RTC wake the system
// - Shelf wakes only on two pins, low
// - Global resets clear everything except the reset cause
// - Power-on low, pin low, brown-out high
// - Soft reset spares the reset generator
// - Separate soft reset per block and MCU
// - Last reset cause readable by software
// - Power-on reset held until clock, supply ready
// - Power-on reset lasts its guaranteed interval
// - Fast clock is 62.4 or 48 MHz
// - Power-down keeps slow clock, stops fast
// - Reset pin and shelf pins leave shelf
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pswr_top
    import pswr_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int POR_WAIT = POR_CYCLES
)(
    input wire logic clock,                      // 200 MHz clock
    input wire logic srst,                       // Sync reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
    input wire logic s_axi_awvalid,              // Write address valid
    output logic s_axi_awready,                  // Write address ready
    input wire logic [31:0] s_axi_wdata,         // Write data
    input wire logic [3:0] s_axi_wstrb,          // Write strobes
    input wire logic s_axi_wvalid,               // Write data valid
    output logic s_axi_wready,                   // Write data ready
    output logic [1:0] s_axi_bresp,              // Write response
    output logic s_axi_bvalid,                   // Write response valid
    input wire logic s_axi_bready,               // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
    input wire logic s_axi_arvalid,              // Read address valid
    output logic s_axi_arready,                  // Read address ready
    output logic [31:0] s_axi_rdata,             // Read data
    output logic [1:0] s_axi_rresp,              // Read response
    output logic s_axi_rvalid,                   // Read data valid
    input wire logic s_axi_rready,               // Read data ready
    input wire logic power_on_reset_n,           // Power-on reset, low
    input wire logic reset_pin_n,                // Reset pin, low
    input wire logic brown_out_reset,            // Brown-out, high
    input wire logic watchdog_expired,           // Watchdog expiry pulse
    input wire logic main_clock_ready,           // Main clock ready
    input wire logic digital_supply_ready,       // Digital supply ready
    input wire logic mcu_supply_ready,           // MCU supply ready
    input wire logic ring_osc_ready,             // 48 MHz oscillator ready
    input wire logic xtal_ready,                 // 38.4 MHz crystal ready
    input wire logic [NUM_PINS-1:0] wake_pin,    // Wake pins, high wakes
    input wire logic comparator_one_wake,        // Comparator one event
    input wire logic comparator_two_wake,        // Comparator two event
    input wire logic rtc_match_wake,             // RTC match event
    input wire logic rtc_second_wake,            // RTC per-second event
    input wire logic ext_irq_wake,               // Interrupt controller wake
    input wire logic lf_tick,                    // Slow clock tick
    output logic [2:0] power_state,              // Current power state
    output logic radio_enable,                   // Radio on
    output logic mcu_supply_enable,              // MCU supply on
    output logic ring_osc_enable,                // 48 MHz oscillator on
    output logic xtal_enable,                    // Crystal on
    output logic hclk_enable,                    // Fast clock running
    output logic hclk_from_pll,                  // 1: 62.4 MHz, 0: 48 MHz
    output logic lfclk_enable,                   // 32 kHz clock on
    output logic mcu_clock_enable,               // MCU clock gate open
    output logic system_reset,                   // Digital reset, high
    output logic [NUM_BLK-1:0] block_reset,      // Bit 0 MCU, others blocks
    output logic por_active                      // Internal power-on reset
);
    if (ADDR_W < 5)
    begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    pswr_state_t state;
    pswr_state_t next_state;
    logic glob;
    logic sys_rst;
    logic por_hold;
    logic [CAUSE_W-1:0] cause;
    logic [CFG_HCLK_RO:0] cfg;
    logic [WAKE_W-1:0] wake_en;
    logic [NUM_BLK-1:0] blk_soft;
    logic [31:0] st_cnt;
    logic [ADDR_W-1:0] aw_a;
    logic [ADDR_W-1:0] ar_a;
    logic [31:0] w_d;
    logic [3:0] w_s;

    assign glob = srst || !power_on_reset_n || !reset_pin_n || brown_out_reset;

    // Write channel: address and data taken independently, applied together
    logic do_wr;
    logic [31:0] wmask;
    logic wr_cmd;
    logic wr_cfg;
    logic wr_wen;
    logic wr_cause;
    logic wr_soft;
    logic wr_blk;
    logic wr_st;
    logic wr_hit;
    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wmask = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
    assign wr_cmd = do_wr && (aw_a == ADDR_W'(REG_CMD));
    assign wr_cfg = do_wr && (aw_a == ADDR_W'(REG_CFG));
    assign wr_wen = do_wr && (aw_a == ADDR_W'(REG_WAKE_EN));
    assign wr_cause = do_wr && (aw_a == ADDR_W'(REG_CAUSE));
    assign wr_soft = do_wr && (aw_a == ADDR_W'(REG_SOFT));
    assign wr_blk = do_wr && (aw_a == ADDR_W'(REG_BLK));
    assign wr_st = do_wr && (aw_a == ADDR_W'(REG_SLEEP_TMR));
    assign wr_hit = (aw_a[1:0] == 2'h0) && (aw_a <= ADDR_W'(REG_SLEEP_TMR));

    logic [31:0] wv;
    logic sw_sys;
    logic [CAUSE_W-1:0] cause_clr;
    logic [2:0] cmd_tgt;
    logic cmd_go;
    assign wv = w_d & wmask;
    assign sw_sys = wr_soft && wv[SOFT_SYS];
    assign cause_clr = wr_cause ? wv[CAUSE_W-1:0] : '0;
    assign cmd_tgt = wv[2:0];
    assign cmd_go = wr_cmd && w_s[0];

    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_a <= '0;
            w_d <= '0;
            w_s <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_a <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Software state
    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            cfg <= '0;
            wake_en <= '0;
            blk_soft <= '0;
        end
        else
        begin
            if (wr_cfg)
                cfg <= (cfg & ~wmask[CFG_HCLK_RO:0]) | wv[CFG_HCLK_RO:0];
            if (wr_wen)
                wake_en <= (wake_en & ~wmask[WAKE_W-1:0]) | wv[WAKE_W-1:0];
            if (wr_blk)
                blk_soft <= (blk_soft & ~wmask[NUM_BLK-1:0]) | wv[NUM_BLK-1:0];
        end
    end

    // Sleep timer: loaded by software, counts slow ticks in sleep and power-down
    logic st_run;
    logic st_fire;
    assign st_run = (state == PS_SLEEP) || (state == PS_PDOWN);
    assign st_fire = st_run && lf_tick && (st_cnt == 32'h00000001);

    always_ff @(posedge clock)
    begin
        if (glob)
            st_cnt <= '0;
        else if (wr_st)
            st_cnt <= (st_cnt & ~wmask) | wv;
        else if (st_run && lf_tick && (st_cnt != '0))
            st_cnt <= st_cnt - 32'h00000001;
    end

    // Wake decode
    logic [WAKE_W-1:0] wake_src;
    logic wake_hit;
    logic shelf_hit;
    logic ramp_done;
    logic tgt_ok;
    assign wake_src = {wake_pin, rtc_second_wake, rtc_match_wake, comparator_two_wake,
        comparator_one_wake, st_fire};
    assign wake_hit = |(wake_src & wake_en);
    assign shelf_hit = !wake_pin[SHELF_PIN_A] || !wake_pin[SHELF_PIN_B];
    assign ramp_done = mcu_supply_ready && ring_osc_ready && !por_hold;
    assign tgt_ok = (cmd_tgt == PS_RADIO) || (cmd_tgt == PS_SLEEP) || (cmd_tgt == PS_PDOWN)
        || (cmd_tgt == PS_DPDOWN) || (cmd_tgt == PS_SHELF);

    always_comb
    begin
        next_state = state;
        case (state)
            PS_RAMP: next_state = ramp_done ? PS_ACTIVE : state;
            PS_ACTIVE: next_state = (cmd_go && tgt_ok) ? pswr_state_t'(cmd_tgt) : state;
            PS_RADIO: next_state = (cmd_go && (cmd_tgt == PS_ACTIVE)) ? PS_ACTIVE : state;
            PS_SLEEP: next_state = (wake_hit || ext_irq_wake) ? PS_ACTIVE : state;
            PS_PDOWN: next_state = (wake_hit || ext_irq_wake) ? PS_RAMP : state;
            PS_DPDOWN: next_state = wake_hit ? PS_RAMP : state;
            PS_SHELF: next_state = shelf_hit ? PS_RAMP : state;
            default: next_state = PS_RAMP;
        endcase
    end

    // Outputs follow the next state so they change with the state register
    logic n_run;
    logic n_ramp;
    logic n_lf;
    assign n_run = (next_state == PS_ACTIVE) || (next_state == PS_RADIO);
    assign n_ramp = next_state == PS_RAMP;
    assign n_lf = (next_state != PS_DPDOWN) && (next_state != PS_SHELF);

    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            state <= PS_RAMP;
            power_state <= PS_RAMP;
            radio_enable <= 1'b0;
            mcu_supply_enable <= 1'b1;
            ring_osc_enable <= 1'b1;
            xtal_enable <= 1'b1;
            hclk_enable <= 1'b0;
            hclk_from_pll <= 1'b0;
            lfclk_enable <= 1'b1;
            mcu_clock_enable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            power_state <= next_state;
            radio_enable <= next_state == PS_RADIO;
            mcu_supply_enable <= n_run || n_ramp || (next_state == PS_SLEEP);
            ring_osc_enable <= n_run || n_ramp || (next_state == PS_SLEEP);
            xtal_enable <= n_run || n_ramp || (next_state == PS_SLEEP);
            hclk_enable <= n_run || (next_state == PS_SLEEP);
            hclk_from_pll <= (next_state == PS_RADIO) || !cfg[CFG_HCLK_RO];
            lfclk_enable <= n_lf;
            // Gate stays shut until the crystal reports ready when asked to wait
            mcu_clock_enable <= n_run && (!cfg[CFG_XTAL_WAIT] || xtal_ready);
        end
    end

    for (genvar i = 0; i < NUM_BLK; i++)
    begin : g_blk
        always_ff @(posedge clock)
        begin
            if (glob)
            begin
                block_reset[i] <= 1'b1;
            end
            else
            begin
                block_reset[i] <= sys_rst || blk_soft[i];
            end
        end
    end

    pswr_rstgen #(
        .POR_WAIT(POR_WAIT)
    ) u_rstgen (
        .clock(clock),
        .srst(srst),
        .glob(glob),
        .por_low(!power_on_reset_n),
        .pin_low(!reset_pin_n),
        .brown_high(brown_out_reset),
        .wdt(watchdog_expired),
        .sw_sys(sw_sys),
        .clk_ready(main_clock_ready),
        .sup_ready(digital_supply_ready),
        .cause_clr(cause_clr),
        .por_hold(por_hold),
        .sys_rst(sys_rst),
        .cause(cause)
    );
    assign system_reset = sys_rst;
    assign por_active = por_hold;

    // Read channel
    logic do_rd;
    logic [31:0] rd_val;
    logic rd_hit;
    assign do_rd = !s_axi_arready && !s_axi_rvalid;
    assign rd_hit = (ar_a[1:0] == 2'h0) && (ar_a <= ADDR_W'(REG_SLEEP_TMR));

    always_comb
    begin
        rd_val = '0;
        case (ar_a)
            ADDR_W'(REG_CMD): rd_val = 32'(state);
            ADDR_W'(REG_CFG): rd_val = 32'(cfg);
            ADDR_W'(REG_WAKE_EN): rd_val = 32'(wake_en);
            ADDR_W'(REG_STATUS): rd_val = 32'({por_hold, mcu_clock_enable, xtal_ready, state});
            ADDR_W'(REG_CAUSE): rd_val = 32'(cause);
            ADDR_W'(REG_BLK): rd_val = 32'(blk_soft);
            ADDR_W'(REG_SLEEP_TMR): rd_val = st_cnt;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (glob)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            ar_a <= '0;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_a <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (do_rd)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ===== testbench/pswr_far_model.sv
// Supply, ring oscillator and crystal model on the far side
`timescale 1ns/1ps
module pswr_far_model #(
    parameter int DLY = 3
)(
    input wire logic clock, // Clock
    input wire logic mcu_supply_enable, // Supply on
    input wire logic ring_osc_enable, // Oscillator on
    input wire logic xtal_enable, // Crystal on
    output logic mcu_supply_ready, // Supply settled
    output logic ring_osc_ready, // Oscillator settled
    output logic xtal_ready // Crystal settled
);
    int ramp = 0;
    int xcnt = 0;
    // Crystal settles long after the supply so a held clock gate shows
    always_ff @(posedge clock)
    begin
        ramp <= mcu_supply_enable ? ramp + 1 : 0;
        xcnt <= xtal_enable ? xcnt + 1 : 0;
    end
    assign mcu_supply_ready = ramp > DLY;
    assign ring_osc_ready = ring_osc_enable && ramp > DLY + 1;
    assign xtal_ready = xcnt > 4 * DLY;
endmodule

// ===== testbench/pswr_sva.sv
// Port checker for the power state controller
`timescale 1ns/1ps
module pswr_sva
    import pswr_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic srst, // Reset
    input wire logic power_on_reset_n, // Reset
    input wire logic reset_pin_n, // Reset
    input wire logic brown_out_reset, // Reset
    input wire logic main_clock_ready, // Ready
    input wire logic digital_supply_ready, // Ready
    input wire logic mcu_supply_ready, // Ready
    input wire logic ring_osc_ready, // Ready
    input wire logic [NUM_PINS-1:0] wake_pin, // Pins
    input wire logic [2:0] power_state, // State
    input wire logic mcu_supply_enable, // Enable
    input wire logic ring_osc_enable, // Enable
    input wire logic xtal_enable, // Enable
    input wire logic hclk_enable, // Enable
    input wire logic lfclk_enable, // Enable
    input wire logic mcu_clock_enable, // Gate
    input wire logic system_reset, // Reset out
    input wire logic [NUM_BLK-1:0] block_reset, // Reset out
    input wire logic por_active // Reset out
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst || !power_on_reset_n || !reset_pin_n || brown_out_reset);
    a_ramp_power: assert property (power_state == PS_RAMP
        |-> &{mcu_supply_enable, ring_osc_enable, xtal_enable}) else $error("ramp supply off");
    a_ramp_exit: assert property (power_state == PS_RAMP && mcu_supply_ready
        && ring_osc_ready && !por_active |=> power_state == PS_ACTIVE) else $error("ramp stuck");
    a_por_hold: assert property (por_active && !(main_clock_ready && digital_supply_ready)
        |=> por_active) else $error("por released early");
    a_por_sys: assert property ($fell(por_active) |-> $fell(system_reset))
        else $error("system reset not released");
    a_gate_state: assert property (mcu_clock_enable |-> power_state inside {PS_ACTIVE, PS_RADIO})
        else $error("gate open");
    a_pdown_clk: assert property (power_state == PS_PDOWN |-> lfclk_enable && !hclk_enable)
        else $error("pdown clocks");
    a_shelf_wake: assert property (power_state == PS_SHELF && !wake_pin[SHELF_PIN_A]
        |=> power_state == PS_RAMP) else $error("shelf wake");
    a_blk_follow: assert property (system_reset |=> &block_reset)
        else $error("block reset");
    cover property (power_state == PS_SHELF);
    cover property (power_state == PS_RADIO);
    cover property ($fell(por_active));
endmodule
bind pswr_top pswr_sva u_sva (.*);

// ===== testbench/tb_power_state_wakeup_reset_control.sv
// Register level bench for the power state controller
`timescale 1ns/1ps
module tb_power_state_wakeup_reset_control
    import pswr_pkg::*;
;
    logic clock = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, mcu_supply_ready, ring_osc_ready, xtal_ready;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, wb;
    logic power_on_reset_n = 1, reset_pin_n = 1, brown_out_reset = 0, watchdog_expired = 0;
    logic main_clock_ready = 0, digital_supply_ready = 1, ext_irq_wake = 0, lf_tick = 0;
    logic comparator_one_wake = 0, comparator_two_wake = 0, rtc_match_wake = 0, rtc_second_wake = 0;
    logic [NUM_PINS-1:0] wake_pin = 18'h24000;
    logic [2:0] power_state;
    logic radio_enable, mcu_supply_enable, ring_osc_enable, xtal_enable, hclk_enable, hclk_from_pll;
    logic lfclk_enable, mcu_clock_enable, system_reset, por_active;
    logic [NUM_BLK-1:0] block_reset;
    logic [2:0] tgt [5] = '{3'h5, 3'h3, 3'h2, 3'h6, 3'h7};
    logic [31:0] en [5] = '{32'h0, 32'h0, 32'h2, 32'h100, 32'h0};
    int err_total = 0, comparisons = 0, cyc = 0;
    pswr_top #(.POR_WAIT(20)) dut (.*);
    pswr_far_model far (.*);
    initial forever #2.5 clock = ~clock;
    task complete_run;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        wb = s_axi_bresp;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp, input string n);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        chk(n, rd, exp);
    endtask
    task ws(input logic [2:0] s);
        for (int i = 0; i < 400 && power_state !== s; i++)
            @(posedge clock);
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run;
        end
    end
    initial
    begin
        repeat (5) @(posedge clock);
        srst <= 0;
        repeat (40) @(posedge clock);
        rchk(REG_STATUS, 32'h28, "status_ramp");
        main_clock_ready <= 1;
        ws(PS_ACTIVE);
        rchk(8'h20, 32'h0, "unmapped");
        chk("rresp", rr, RESP_SLVERR);
        axw(8'h20, 32'h1);
        chk("bresp", wb, RESP_SLVERR);
        for (int k = 0; k < 3; k++)
        begin
            power_on_reset_n <= k != 0;
            reset_pin_n <= k != 1;
            brown_out_reset <= k == 2;
            repeat (3) @(posedge clock);
            {power_on_reset_n, reset_pin_n, brown_out_reset} <= 3'h6;
            repeat (18) @(posedge clock);
            chk("por_count", por_active, 32'h1);
            ws(PS_ACTIVE);
            rchk(REG_CAUSE, 32'h1 << k, "cause_global");
            axw(REG_CAUSE, 32'h1f);
        end
        axw(REG_CFG, 32'h3);
        axw(REG_SOFT, 32'h1);
        @(posedge clock);
        chk("soft_reset", system_reset, 32'h1);
        repeat (20) @(posedge clock);
        rchk(REG_CFG, 32'h3, "cfg_kept");
        rchk(REG_CAUSE, 32'h8, "cause_soft");
        axw(REG_CAUSE, 32'h1f);
        watchdog_expired <= 1;
        @(posedge clock);
        watchdog_expired <= 0;
        repeat (20) @(posedge clock);
        rchk(REG_CAUSE, 32'h10, "cause_wdt");
        axw(REG_BLK, 32'h5);
        @(posedge clock);
        chk("block_reset", block_reset, 32'h5);
        axw(REG_BLK, 32'h0);
        foreach (tgt[i])
        begin
            axw(REG_WAKE_EN, en[i]);
            axw(REG_CMD, tgt[i]);
            rchk(REG_CMD, tgt[i], "enter");
            if (tgt[i] == 3'h5)
            begin
                chk("radio", {radio_enable, hclk_from_pll}, 32'h3);
                axw(REG_CMD, 32'h1);
            end
            if (tgt[i] == 3'h3) ext_irq_wake <= 1;
            if (tgt[i] == 3'h2) comparator_one_wake <= 1;
            if (tgt[i] == 3'h7) wake_pin[SHELF_PIN_A] <= 0;
            if (tgt[i] == 3'h6)
            begin
                comparator_two_wake <= 1;
                repeat (9) @(posedge clock);
                chk("masked", power_state, 32'h6);
                wake_pin[3] <= 1;
            end
            ws(PS_ACTIVE);
            chk("woken", power_state, 32'h1);
            if (tgt[i] == 3'h6) chk("gate_held", mcu_clock_enable, 32'h0);
            {ext_irq_wake, comparator_one_wake, comparator_two_wake} <= 3'h0;
            wake_pin <= 18'h24000;
            repeat (20) @(posedge clock);
            chk("gate_open", mcu_clock_enable, 32'h1);
        end
        axw(REG_WAKE_EN, 32'h1);
        axw(REG_SLEEP_TMR, 32'h3);
        axw(REG_CMD, 32'h3);
        for (int t = 0; t < 3; t++)
        begin
            chk("sleeping", power_state, 32'h3);
            lf_tick <= 1;
            @(posedge clock);
            lf_tick <= 0;
            @(posedge clock);
        end
        ws(PS_ACTIVE);
        chk("timer_wake", power_state, 32'h1);
        chk("hclk_sel", hclk_from_pll, 32'h0);
        complete_run;
    end
endmodule
